// file: verilog/apd_cmd.sv
// Functional notes
// RULE1: separate basic and home/manual parameter commands, each for one chosen axis.
// RULE2: non-common parameter change on an operating axis is refused with error 471.
// RULE3: axis selector 0 picks the first axis, 1 the second; two axes exist.
// RULE4: an I/O parameter change stores the given value whole, no item needed.
// RULE5: operation data write on an operating axis is refused with error 472.
// RULE6: 150 steps per axis; step number 0 means the axis's current step.
// RULE7: item codes 1 to 16 select goal position through repeat step in order.
// RULE8: accepted operation data write stores value in chosen item, step and axis.
// RULE9: teaching on an operating axis is refused: 461 for position, 463 for speed.
// RULE10: teach method 1 also commits to nonvolatile store, 0 only to RAM.
// RULE11: the host keeps ROM teaching within 100,000 operations in total.
// RULE12: teach item 0 writes goal positions, 1 writes operating speeds.
// RULE13: teaching covers count consecutive steps from the first step, at most 16.
// RULE14: teach entry n is read from source word offset 2*(n-1), 0 to 30.
// RULE15: save copies parameters and operation data of the chosen axes to flash.
// RULE16: save while either axis operates is refused with error 172.
// RULE17: done goes 1 on clean completion and holds until the next command; 0 on failure.
// RULE18: a failed command shows its error number on the error output.
// RULE19: the host issues commands only to axes not operating and free of error.
// RULE20: a refused command changes no stored parameter, data or teaching value.
`timescale 1ns/1ps
module apd_cmd import apd_pkg::*; #(
   parameter int DW = 32
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // command strobes
   input wire logic set_basic_param_cmd,
   input wire logic set_home_manual_param_cmd,
   input wire logic set_operation_data_cmd,
   input wire logic teach_array_cmd,
   input wire logic save_to_flash_cmd,
   // command arguments
   input wire logic axis_sel,
   input wire logic common_param_sel,
   input wire logic io_param_sel,
   input wire logic [3:0] param_item,
   input wire logic [DW-1:0] param_value,
   input wire logic [7:0] step_no,
   input wire logic [4:0] data_item,
   input wire logic [DW-1:0] data_value,
   input wire logic teach_to_rom,
   input wire logic teach_item,
   input wire logic [7:0] teach_first_step,
   input wire logic [4:0] teach_count,
   input wire logic [1:0] save_axes,
   // axis state
   input wire logic [1:0] axis_operating,
   input wire logic [7:0] cur_step_x,
   input wire logic [7:0] cur_step_y,
   // teach source block
   output logic src_rd,
   output logic [4:0] src_addr,
   input wire logic [DW-1:0] src_data,
   // flash write
   output logic flash_wr_valid,
   input wire logic flash_wr_ready,
   output logic [AW-1:0] flash_wr_addr,
   output logic [DW-1:0] flash_wr_data,
   // result
   output logic cmd_busy,
   output logic cmd_done,
   output logic [15:0] cmd_error
);
   if (DW < 32) begin : g_bad_dw
      $error("data width below 32");
   end

   typedef struct packed {
      apd_state_t st;
      logic busy;
      logic done;
      logic [15:0] err;
      logic ax;
      logic rom;
      logic [3:0] item;
      logic [7:0] first;
      logic [4:0] cnt;
      logic [4:0] ridx;
      logic pend;
      logic [4:0] widx;
      logic src_rd;
      logic [4:0] src_addr;
      logic cp_start;
      logic [1:0] cp_axes;
   } apd_cmd_t;

   apd_cmd_t s_q, s_d;
   logic wr_en;
   logic [AW-1:0] wr_addr;
   logic [DW-1:0] wr_data;
   logic cp_rd_en;
   logic [AW-1:0] cp_rd_addr;
   logic [DW-1:0] cp_rd_data;
   logic cp_done;
   logic any_cmd;
   logic param_cmd;
   logic ax_run;
   logic [7:0] eff_step;
   logic [7:0] row_sel;
   logic [8:0] teach_end;
   logic data_bad;
   logic teach_bad;
   logic idle_cmd;

   assign any_cmd = set_basic_param_cmd | set_home_manual_param_cmd | set_operation_data_cmd
                    | teach_array_cmd | save_to_flash_cmd;
   assign param_cmd = set_basic_param_cmd | set_home_manual_param_cmd; // RULE1
   assign ax_run = axis_operating[axis_sel]; // RULE3
   assign eff_step = (step_no == 8'h00) ? (axis_sel ? cur_step_y : cur_step_x) : step_no; // RULE6
   assign data_bad = (eff_step == 8'h00) || (eff_step > STEP_LAST) || (data_item == 5'h00)
                     || (data_item > ITEM_CODE_MAX);
   assign teach_end = {1'b0, teach_first_step} + {4'h0, teach_count} - 9'h001;
   assign teach_bad = (teach_count == 5'h00) || (teach_count > TEACH_MAX)
                      || (teach_first_step == 8'h00) || (teach_end > {1'b0, STEP_LAST}); // RULE13
   assign row_sel = set_basic_param_cmd && !io_param_sel ? ROW_BASIC : ROW_HOME;
   assign idle_cmd = (s_q.st == ST_IDLE) && any_cmd;

   assign cmd_busy = s_q.busy;
   assign cmd_done = s_q.done;
   assign cmd_error = s_q.err;
   assign src_rd = s_q.src_rd;
   assign src_addr = s_q.src_addr;

   apd_store #(.DW(DW)) u_store (
      .clk(clk),
      .wr_en(wr_en),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .rd_en(cp_rd_en),
      .rd_addr(cp_rd_addr),
      .rd_data(cp_rd_data)
   );

   apd_flash_copier #(.DW(DW)) u_copier (
      .clk(clk),
      .rst_n(rst_n),
      .start(s_q.cp_start),
      .axes(s_q.cp_axes),
      .done(cp_done),
      .rd_en(cp_rd_en),
      .rd_addr(cp_rd_addr),
      .rd_data(cp_rd_data),
      .flash_wr_valid(flash_wr_valid),
      .flash_wr_ready(flash_wr_ready),
      .flash_wr_addr(flash_wr_addr),
      .flash_wr_data(flash_wr_data)
   );

   always_comb begin
      s_d = s_q;
      s_d.src_rd = 1'b0;
      s_d.cp_start = 1'b0;
      wr_en = 1'b0;
      wr_addr = '0;
      wr_data = '0;
      case (s_q.st)
         ST_IDLE: if (any_cmd) begin
            s_d.done = 1'b0; // RULE17
            s_d.err = ERR_NONE;
            s_d.ax = axis_sel; // RULE3
            if (param_cmd) begin
               if (!common_param_sel && ax_run) begin
                  s_d.err = ERR_PARAM_RUN; // RULE2 RULE20
               end else begin
                  wr_en = 1'b1;
                  wr_addr = store_addr(axis_sel & ~common_param_sel, row_sel,
                                       io_param_sel ? IO_ITEM : param_item); // RULE1 RULE4
                  wr_data = param_value; // RULE4
                  s_d.done = 1'b1;
               end
            end else if (set_operation_data_cmd) begin
               if (ax_run) begin
                  s_d.err = ERR_DATA_RUN; // RULE5 RULE20
               end else if (data_bad) begin
                  s_d.err = ERR_RANGE; // RULE18
               end else begin
                  wr_en = 1'b1;
                  wr_addr = store_addr(axis_sel, eff_step, 4'(data_item - 5'h01)); // RULE7 RULE8
                  wr_data = data_value; // RULE8
                  s_d.done = 1'b1;
               end
            end else if (teach_array_cmd) begin
               if (ax_run) begin
                  s_d.err = teach_item ? ERR_TSPD_RUN : ERR_TPOS_RUN; // RULE9 RULE20
               end else if (teach_bad) begin
                  s_d.err = ERR_RANGE; // RULE18
               end else begin
                  s_d.st = ST_TEACH;
                  s_d.busy = 1'b1;
                  s_d.rom = teach_to_rom;
                  s_d.item = teach_item ? ITEM_SPD : ITEM_POS; // RULE12
                  s_d.first = teach_first_step;
                  s_d.cnt = teach_count;
                  s_d.ridx = '0;
                  s_d.pend = 1'b0;
               end
            end else begin
               if (|axis_operating) begin
                  s_d.err = ERR_SAVE_RUN; // RULE16
               end else if (save_axes == 2'b00) begin
                  s_d.err = ERR_RANGE; // RULE18
               end else begin
                  s_d.st = ST_SAVE;
                  s_d.busy = 1'b1;
                  s_d.cp_start = 1'b1; // RULE15
                  s_d.cp_axes = save_axes;
               end
            end
         end
         ST_TEACH: begin
            s_d.pend = 1'b0;
            if (s_q.ridx < s_q.cnt) begin
               s_d.src_rd = 1'b1;
               s_d.src_addr = 5'(s_q.ridx * TEACH_STRIDE); // RULE14
               s_d.ridx = s_q.ridx + 5'h01;
               s_d.widx = s_q.ridx;
               s_d.pend = 1'b1;
            end
            if (s_q.pend) begin
               wr_en = 1'b1;
               wr_addr = store_addr(s_q.ax, s_q.first + {3'h0, s_q.widx}, s_q.item); // RULE13
               wr_data = src_data;
               if (s_q.widx == s_q.cnt - 5'h01) begin
                  if (s_q.rom) begin
                     s_d.st = ST_SAVE;
                     s_d.cp_start = 1'b1; // RULE10
                     s_d.cp_axes = s_q.ax ? 2'b10 : 2'b01;
                  end else begin
                     s_d.st = ST_IDLE;
                     s_d.busy = 1'b0;
                     s_d.done = 1'b1; // RULE10 RULE17
                  end
               end
            end
         end
         ST_SAVE: if (cp_done) begin
            s_d.st = ST_IDLE;
            s_d.busy = 1'b0;
            s_d.done = 1'b1; // RULE17
         end
         default: s_d.st = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '{st: ST_IDLE, default: '0};
      end else begin
         s_q <= s_d;
      end
   end

   logic [5:0] rd_count;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_count <= '0;
      end else if (s_q.st == ST_IDLE) begin
         rd_count <= '0;
      end else if (s_q.src_rd) begin
         rd_count <= rd_count + 6'h01;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_param_run_err: assert property (idle_cmd && param_cmd && !common_param_sel && ax_run // RULE2
      |=> cmd_error == ERR_PARAM_RUN && !cmd_done) else $error("param refusal wrong");
   a_data_run_err: assert property (idle_cmd && !param_cmd // RULE5
      && set_operation_data_cmd && ax_run
      |=> cmd_error == ERR_DATA_RUN && !cmd_done) else $error("data refusal wrong");
   a_teach_run_err: assert property (idle_cmd && teach_array_cmd && !param_cmd // RULE9
      && !set_operation_data_cmd && ax_run
      |=> cmd_error == ($past(teach_item) ? ERR_TSPD_RUN : ERR_TPOS_RUN))
      else $error("teach refusal");
   a_save_run_err: assert property (idle_cmd && save_to_flash_cmd && !param_cmd // RULE16
      && !set_operation_data_cmd && !teach_array_cmd && |axis_operating
      |=> cmd_error == ERR_SAVE_RUN) else $error("save refusal wrong");
   a_refuse_no_write: assert property (idle_cmd && ax_run // RULE20
      && !(param_cmd && common_param_sel) |-> !wr_en) else $error("refused command wrote");
   a_data_write_ok: assert property (idle_cmd && set_operation_data_cmd && !param_cmd // RULE8
      && !ax_run && !data_bad |-> wr_en && wr_data == data_value
      ##1 cmd_done && cmd_error == ERR_NONE) else $error("data write missing");
   a_done_holds: assert property (cmd_done && !any_cmd |=> cmd_done) else $error("done dropped"); // RULE17
   a_fail_not_done: assert property (cmd_error != ERR_NONE |-> !cmd_done && !cmd_busy) // RULE18
      else $error("error with done");
   a_teach_first_rd: assert property (idle_cmd && s_d.st == ST_TEACH // RULE14
      |-> ##2 src_rd && src_addr == 5'h00 ##1 !src_rd || src_addr == 5'h02)
      else $error("teach start");
   a_teach_max_rd: assert property (rd_count <= 6'h10) else $error("too many reads"); // RULE13
   a_common_run_ok: assert property (idle_cmd && param_cmd && common_param_sel // RULE2
      |-> wr_en ##1 cmd_done) else $error("common param refused");
   a_save_start: assert property (idle_cmd && save_to_flash_cmd && !param_cmd // RULE15
      && !set_operation_data_cmd && !teach_array_cmd && !(|axis_operating)
      && save_axes != 2'b00 |=> cmd_busy) else $error("save not started");

   c_teach_rom: cover property (s_q.st == ST_TEACH && s_q.rom ##1 s_q.st == ST_SAVE);
   c_save_done: cover property (s_q.st == ST_SAVE && cp_done);
   c_param_refused: cover property (cmd_error == ERR_PARAM_RUN);
   c_teach_ram: cover property (s_q.st == ST_TEACH && !s_q.rom ##1 s_q.st == ST_IDLE);
endmodule : apd_cmd

// file: verilog/apd_pkg.sv
package apd_pkg;
   localparam int AXES = 2;
   localparam int STEPS = 150;
   localparam int ITEMS = 16;
   localparam int ROWS = STEPS + 2;
   localparam logic [7:0] ROW_BASIC = 8'h00;
   localparam logic [7:0] ROW_HOME = 8'h97;
   localparam logic [3:0] IO_ITEM = 4'hF;
   localparam int AW = 13;
   localparam logic [4:0] TEACH_MAX = 5'h10;
   localparam int TEACH_STRIDE = 2;
   localparam logic [3:0] ITEM_POS = 4'h0;
   localparam logic [3:0] ITEM_SPD = 4'h2;
   localparam logic [7:0] STEP_LAST = 8'h96;
   localparam logic [4:0] ITEM_CODE_MAX = 5'h10;
   // error numbers, decimal 471, 472, 461, 463, 172, 499
   localparam logic [15:0] ERR_NONE = 16'h0000;
   localparam logic [15:0] ERR_PARAM_RUN = 16'h01D7;
   localparam logic [15:0] ERR_DATA_RUN = 16'h01D8;
   localparam logic [15:0] ERR_TPOS_RUN = 16'h01CD;
   localparam logic [15:0] ERR_TSPD_RUN = 16'h01CF;
   localparam logic [15:0] ERR_SAVE_RUN = 16'h00AC;
   localparam logic [15:0] ERR_RANGE = 16'h01F3;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_TEACH = 3'h2,
      ST_SAVE = 3'h4
   } apd_state_t;

   typedef enum logic [3:0] {
      CP_IDLE = 4'h1,
      CP_RD = 4'h2,
      CP_CAP = 4'h4,
      CP_OUT = 4'h8
   } apd_cp_state_t;

   // word address of one item: axis region, row, item
   function automatic logic [AW-1:0] store_addr(input logic ax, input logic [7:0] row,
                                                input logic [3:0] item);
      logic [AW-1:0] base;
      base = ax ? AW'(ROWS * ITEMS) : '0;
      return base + AW'({row, item});
   endfunction : store_addr
endpackage : apd_pkg

// file: verilog/apd_store.sv
`timescale 1ns/1ps
module apd_store import apd_pkg::*; #(
   parameter int DW = 32
) (
   // clock
   input wire logic clk,
   // write port
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [DW-1:0] wr_data,
   // read port, data one cycle later
   input wire logic rd_en,
   input wire logic [AW-1:0] rd_addr,
   output logic [DW-1:0] rd_data
);
   localparam int DEPTH = AXES * ROWS * ITEMS;
   logic [DW-1:0] mem [0:DEPTH-1];

   if (DEPTH > (1 << AW)) begin : g_bad_depth
      $error("store depth exceeds address width");
   end

   // parameters and operation data of both axes
   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      if (rd_en) begin
         rd_data <= mem[rd_addr];
      end
   end
endmodule : apd_store

// file: verilog/apd_flash_copier.sv
`timescale 1ns/1ps
module apd_flash_copier import apd_pkg::*; #(
   parameter int DW = 32
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // control
   input wire logic start,
   input wire logic [1:0] axes,
   output logic done,
   // store read
   output logic rd_en,
   output logic [AW-1:0] rd_addr,
   input wire logic [DW-1:0] rd_data,
   // flash write
   output logic flash_wr_valid,
   input wire logic flash_wr_ready,
   output logic [AW-1:0] flash_wr_addr,
   output logic [DW-1:0] flash_wr_data
);
   localparam int LAST = ROWS * ITEMS - 1;

   typedef struct packed {
      apd_cp_state_t st;
      logic [1:0] axes;
      logic ax;
      logic [11:0] idx;
      logic valid;
      logic [AW-1:0] addr;
      logic [DW-1:0] data;
      logic done;
   } apd_cp_t;

   apd_cp_t s_q, s_d;
   logic [AW-1:0] cur_addr;

   assign cur_addr = store_addr(s_q.ax, s_q.idx[11:4], s_q.idx[3:0]);
   assign rd_en = (s_q.st == CP_RD);
   assign rd_addr = cur_addr;
   assign done = s_q.done;
   assign flash_wr_valid = s_q.valid;
   assign flash_wr_addr = s_q.addr;
   assign flash_wr_data = s_q.data;

   // walks every word of each selected axis into flash
   always_comb begin
      s_d = s_q;
      s_d.done = 1'b0;
      case (s_q.st)
         CP_IDLE: if (start) begin
            s_d.axes = axes;
            s_d.ax = ~axes[0];
            s_d.idx = '0;
            s_d.st = (axes == 2'b00) ? CP_IDLE : CP_RD;
            s_d.done = (axes == 2'b00);
         end
         CP_RD: s_d.st = CP_CAP;
         CP_CAP: begin
            s_d.valid = 1'b1;
            s_d.addr = cur_addr;
            s_d.data = rd_data;
            s_d.st = CP_OUT;
         end
         CP_OUT: if (flash_wr_ready) begin
            s_d.valid = 1'b0;
            s_d.st = CP_RD;
            if (s_q.idx != 12'(LAST)) begin
               s_d.idx = s_q.idx + 12'h001;
            end else if (!s_q.ax && s_q.axes[1]) begin
               s_d.ax = 1'b1;
               s_d.idx = '0;
            end else begin
               s_d.st = CP_IDLE;
               s_d.done = 1'b1;
            end
         end
         default: s_d.st = CP_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '{st: CP_IDLE, default: '0};
      end else begin
         s_q <= s_d;
      end
   end
endmodule : apd_flash_copier

// file: testbench/apd_partner.sv
`timescale 1ns/1ps
module apd_partner import apd_pkg::*; (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // teach source block
   input wire logic src_rd,
   input wire logic [4:0] src_addr,
   output logic [31:0] src_data,
   // flash write
   input wire logic flash_wr_valid,
   output logic flash_wr_ready,
   input wire logic [AW-1:0] flash_wr_addr,
   input wire logic [31:0] flash_wr_data
);
   logic [31:0] fm [0:8191];
   int cnt_lo;
   int cnt_hi;
   logic [1:0] tick_q;
   // source word answered in the cycle of the read, when the command logic takes it
   assign src_data = src_rd ? (32'hA500_0000 | 32'(src_addr)) : 32'h5A5A_5A5A;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flash_wr_ready <= 1'b0;
         tick_q <= 2'h0;
         cnt_lo <= 0;
         cnt_hi <= 0;
      end else begin
         tick_q <= tick_q + 2'h1;
         // ready after a varying stall, one word per handshake
         flash_wr_ready <= flash_wr_valid && !flash_wr_ready && tick_q != 2'h0;
         if (flash_wr_valid && flash_wr_ready) begin
            fm[flash_wr_addr] <= flash_wr_data;
            if (int'(flash_wr_addr) < ROWS * ITEMS) begin
               cnt_lo <= cnt_lo + 1;
            end else begin
               cnt_hi <= cnt_hi + 1;
            end
         end
      end
   end
endmodule : apd_partner

// file: testbench/test_axis_parameter_data_setting.sv
`timescale 1ns/1ps
module test_axis_parameter_data_setting import apd_pkg::*;;
   typedef struct {
      logic [1:0] k;
      logic ax;
      logic [1:0] op;
      logic cm;
      logic io;
      logic [7:0] st;
      logic [4:0] it;
      logic [31:0] v;
      logic [15:0] e;
   } apd_row_t;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [4:0] strb = 5'h00;
   logic axis_sel = 1'b0, common_param_sel = 1'b0, io_param_sel = 1'b0;
   logic [3:0] param_item = 4'h0;
   logic [31:0] param_value = 32'h0, data_value = 32'h0, src_data, flash_wr_data;
   logic [7:0] step_no = 8'h00, teach_first_step = 8'h00;
   logic [7:0] cur_step_x = 8'h03, cur_step_y = 8'h07;
   logic [4:0] data_item = 5'h00, teach_count = 5'h00, src_addr;
   logic teach_to_rom = 1'b0, teach_item = 1'b0;
   logic [1:0] save_axes = 2'h0, axis_operating = 2'h0;
   logic src_rd, flash_wr_valid, flash_wr_ready, cmd_busy, cmd_done;
   logic [AW-1:0] flash_wr_addr;
   logic [15:0] cmd_error;
   int err_count = 0;
   int samples_checked = 0;
   int cycles = 0;
   int qa [$];
   logic [31:0] qv [$];
   apd_row_t rows [0:12];
   int lo, hi;

   always #5 clk = ~clk;

   apd_cmd apd_cmd_inst (.clk(clk), .rst_n(rst_n), .set_basic_param_cmd(strb[0]),
      .set_home_manual_param_cmd(strb[1]), .set_operation_data_cmd(strb[2]),
      .teach_array_cmd(strb[3]), .save_to_flash_cmd(strb[4]), .axis_sel(axis_sel),
      .common_param_sel(common_param_sel), .io_param_sel(io_param_sel),
      .param_item(param_item), .param_value(param_value), .step_no(step_no),
      .data_item(data_item), .data_value(data_value), .teach_to_rom(teach_to_rom),
      .teach_item(teach_item), .teach_first_step(teach_first_step),
      .teach_count(teach_count), .save_axes(save_axes), .axis_operating(axis_operating),
      .cur_step_x(cur_step_x), .cur_step_y(cur_step_y), .src_rd(src_rd),
      .src_addr(src_addr), .src_data(src_data), .flash_wr_valid(flash_wr_valid),
      .flash_wr_ready(flash_wr_ready), .flash_wr_addr(flash_wr_addr),
      .flash_wr_data(flash_wr_data), .cmd_busy(cmd_busy), .cmd_done(cmd_done),
      .cmd_error(cmd_error));

   apd_partner apd_partner_inst (.clk(clk), .rst_n(rst_n), .src_rd(src_rd),
      .src_addr(src_addr), .src_data(src_data), .flash_wr_valid(flash_wr_valid),
      .flash_wr_ready(flash_wr_ready), .flash_wr_addr(flash_wr_addr),
      .flash_wr_data(flash_wr_data));

   task automatic give_verdict();
      if (err_count == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : give_verdict

   always @(posedge clk) begin
      cycles++;
      if (cycles == 60000) begin
         err_count++;
         give_verdict();
      end
   end

   task automatic chk_flag(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_flag

   task automatic chk_err(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_err

   task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_data

   function automatic int taddr(input logic ax, input int row, input int idx);
      return (ax ? ROWS * ITEMS : 0) + row * ITEMS + idx;
   endfunction : taddr

   // pulse one strobe, wait out busy, then check the result
   task automatic fire(input logic [4:0] m, input logic [15:0] e);
      int n;
      strb <= m;
      @(posedge clk);
      strb <= 5'h00;
      #1;
      n = 0;
      while (cmd_busy === 1'b1 && n < 30000) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk_err(cmd_error, e);
      chk_flag(cmd_done, e === 16'h0000);
   endtask : fire

   task automatic send(input apd_row_t r);
      logic [7:0] s;
      int a;
      s = (r.st != 8'h00) ? r.st : (r.ax ? cur_step_y : cur_step_x);
      a = taddr(r.ax, (r.k == 2'h0) ? 0 : 151, r.io ? 15 : int'(r.it));
      if (r.k == 2'h2) a = taddr(r.ax, int'(s), int'(r.it) - 1);
      @(posedge clk);
      axis_sel <= r.ax;
      axis_operating <= r.op;
      common_param_sel <= r.cm;
      io_param_sel <= r.io;
      param_item <= r.it[3:0];
      param_value <= r.v;
      step_no <= r.st;
      data_item <= r.it;
      data_value <= r.v;
      fire(5'h01 << r.k, r.e);
      if (r.e == 16'h0000 && !r.cm) begin
         qa.push_back(a);
         qv.push_back(r.v);
      end
   endtask : send

   task automatic teach(input logic ax, rom, it, input logic [7:0] f,
                        input logic [4:0] n, input logic [1:0] op, input logic [15:0] e);
      @(posedge clk);
      axis_sel <= ax;
      teach_to_rom <= rom;
      teach_item <= it;
      teach_first_step <= f;
      teach_count <= n;
      axis_operating <= op;
      fire(5'h08, e);
      if (e == 16'h0000) begin
         for (int j = 0; j < int'(n); j++) begin
            qa.push_back(taddr(ax, int'(f) + j, it ? 2 : 0));
            qv.push_back(32'hA500_0000 | 32'(2 * j));
         end
      end
   endtask : teach

   task automatic save(input logic [1:0] ax, input logic [1:0] op, input logic [15:0] e);
      @(posedge clk);
      save_axes <= ax;
      axis_operating <= op;
      fire(5'h10, e);
   endtask : save

   initial begin
      rows = '{
         '{2'h0, 1'h0, 2'h0, 1'h0, 1'h0, 8'h00, 5'h03, 32'h0000_00A1, 16'h0000},
         '{2'h1, 1'h1, 2'h0, 1'h0, 1'h0, 8'h00, 5'h02, 32'h0000_00B2, 16'h0000},
         '{2'h1, 1'h0, 2'h0, 1'h0, 1'h1, 8'h00, 5'h05, 32'h0000_00C3, 16'h0000},
         '{2'h0, 1'h1, 2'h2, 1'h0, 1'h0, 8'h00, 5'h05, 32'h0000_00D4, 16'h01D7},
         '{2'h1, 1'h0, 2'h1, 1'h1, 1'h0, 8'h00, 5'h04, 32'h0000_00E5, 16'h0000},
         '{2'h1, 1'h0, 2'h1, 1'h0, 1'h0, 8'h00, 5'h04, 32'h0000_00E6, 16'h01D7},
         '{2'h2, 1'h0, 2'h0, 1'h0, 1'h0, 8'h05, 5'h04, 32'h0000_0011, 16'h0000},
         '{2'h2, 1'h0, 2'h1, 1'h0, 1'h0, 8'h05, 5'h04, 32'h0000_0099, 16'h01D8},
         '{2'h2, 1'h1, 2'h1, 1'h0, 1'h0, 8'h96, 5'h10, 32'h0000_0022, 16'h0000},
         '{2'h2, 1'h1, 2'h0, 1'h0, 1'h0, 8'h00, 5'h01, 32'h0000_0033, 16'h0000},
         '{2'h2, 1'h0, 2'h0, 1'h0, 1'h0, 8'h97, 5'h01, 32'h0000_0044, 16'h01F3},
         '{2'h2, 1'h0, 2'h0, 1'h0, 1'h0, 8'h01, 5'h00, 32'h0000_0055, 16'h01F3},
         '{2'h2, 1'h0, 2'h0, 1'h0, 1'h0, 8'h01, 5'h11, 32'h0000_0066, 16'h01F3}};
      repeat (8) @(posedge clk);
      #1;
      chk_flag(cmd_done, 1'b0);
      chk_err(cmd_error, 16'h0000);
      chk_flag(flash_wr_valid, 1'b0);
      chk_flag(src_rd, 1'b0);
      chk_flag(cmd_busy, 1'b0);
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      foreach (rows[i]) send(rows[i]);
      for (int c = 1; c <= 16; c++) begin
         send('{2'h2, 1'h0, 2'h0, 1'h0, 1'h0, 8'h09, 5'(c), 32'h0C00_0000 + c, 16'h0000});
      end
      repeat (3) @(posedge clk);
      #1;
      chk_flag(cmd_done, 1'b1);
      teach(1'b0, 1'b0, 1'b0, 8'h0D, 5'h0A, 2'h0, 16'h0000);
      teach(1'b1, 1'b0, 1'b1, 8'h87, 5'h10, 2'h0, 16'h0000);
      teach(1'b0, 1'b0, 1'b0, 8'h01, 5'h01, 2'h1, 16'h01CD);
      teach(1'b1, 1'b0, 1'b1, 8'h01, 5'h01, 2'h2, 16'h01CF);
      teach(1'b0, 1'b0, 1'b0, 8'h01, 5'h00, 2'h0, 16'h01F3);
      teach(1'b0, 1'b0, 1'b0, 8'h8C, 5'h10, 2'h0, 16'h01F3);
      teach(1'b0, 1'b0, 1'b0, 8'h01, 5'h11, 2'h0, 16'h01F3);
      lo = apd_partner_inst.cnt_lo;
      hi = apd_partner_inst.cnt_hi;
      teach(1'b1, 1'b1, 1'b1, 8'h01, 5'h01, 2'h0, 16'h0000);
      chk_data(32'(apd_partner_inst.cnt_hi - hi), 32'h0000_0980);
      chk_data(32'(apd_partner_inst.cnt_lo - lo), 32'h0000_0000);
      save(2'h1, 2'h2, 16'h00AC);
      save(2'h0, 2'h0, 16'h01F3);
      lo = apd_partner_inst.cnt_lo;
      hi = apd_partner_inst.cnt_hi;
      save(2'h3, 2'h0, 16'h0000);
      chk_data(32'(apd_partner_inst.cnt_lo - lo), 32'h0000_0980);
      chk_data(32'(apd_partner_inst.cnt_hi - hi), 32'h0000_0980);
      foreach (qa[i]) chk_data(apd_partner_inst.fm[qa[i]], qv[i]);
      // reset in the middle of a save, then a plain command must work again
      @(posedge clk);
      save_axes <= 2'h1;
      strb <= 5'h10;
      @(posedge clk);
      strb <= 5'h00;
      repeat (40) @(posedge clk);
      #1;
      chk_flag(cmd_busy, 1'b1);
      @(posedge clk);
      rst_n <= 1'b0;
      #1;
      chk_flag(cmd_busy, 1'b0);
      chk_flag(flash_wr_valid, 1'b0);
      chk_err(cmd_error, 16'h0000);
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      send('{2'h2, 1'h1, 2'h0, 1'h0, 1'h0, 8'h02, 5'h01, 32'h0000_0077, 16'h0000});
      give_verdict();
   end
endmodule : test_axis_parameter_data_setting
